/* core/cbcf_core.sv */
`timescale 1ns/10ps
`default_nettype none
module cbcf_core (
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire logic [15:0]               insn,
   input  wire logic                      insn_valid,
   input  wire logic [7:0]                status_in,
   output logic      [cbcf_pkg::PC_W-1:0] pc,
   output logic      [1:0]                q_phase,
   output logic                           pc_write,
   output logic                           flush,
   output logic                           busy
);
   import cbcf_pkg::*;

   cbcf_dec_if  dif ();

   // quarter count
   cbcf_q_e     q;
   cbcf_q_e     next_q;
   logic [1:0]  next_q_phase;
   // run or no-op cycle
   cbcf_st_e    st;
   cbcf_st_e    next_st;
   // word taken at the decode quarter
   logic [15:0] ir;
   logic [15:0] next_ir;
   logic        hold;
   logic        next_hold;
   // doubled offset read in the literal quarter
   cbcf_pc_t    disp;
   cbcf_pc_t    next_disp;
   // decision and target formed in the process quarter
   logic        jump;
   logic        next_jump;
   cbcf_pc_t    target;
   cbcf_pc_t    next_target;
   // program counter and strobes
   cbcf_pc_t    next_pc;
   logic        next_pc_write;
   logic        next_flush;
   logic        next_busy;

   function automatic logic cbcf_running(input cbcf_st_e s);
      cbcf_running = (s == CBCF_RUN);
   endfunction : cbcf_running

   cbcf_decode u_dec (
      .d (dif.dec)
   );

   assign dif.insn   = ir;
   // status is only sampled, never written back
   assign dif.status = status_in;

   // quarter sequencer, free running: one instruction cycle every four clocks
   always_comb begin
      case (q)
         CBCF_Q1: next_q = CBCF_Q2;
         CBCF_Q2: next_q = CBCF_Q3;
         CBCF_Q3: next_q = CBCF_Q4;
         CBCF_Q4: next_q = CBCF_Q1;
         default: next_q = CBCF_Q1;
      endcase
      // a copy of its own so that q_phase leaves the block from a flop
      next_q_phase = next_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q       <= CBCF_Q1;
         q_phase <= 2'b00;
      end else begin
         q       <= next_q;
         q_phase <= next_q_phase;
      end
   end

   // a taken branch turns the following instruction cycle into a no-op
   always_comb begin
      next_st = st;
      if (q == CBCF_Q4) begin
         case (st)
            CBCF_RUN: begin
               if (jump) begin
                  next_st = CBCF_FLUSH;
               end
            end
            CBCF_FLUSH: begin
               next_st = CBCF_RUN;
            end
            default: begin
               next_st = CBCF_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= CBCF_RUN;
      end else begin
         st <= next_st;
      end
   end

   // decode and literal quarters
   // a word offered in the no-op cycle is dropped: fetch must offer it again
   always_comb begin
      next_ir   = ir;
      next_hold = hold;
      next_disp = disp;
      case (q)
         CBCF_Q1: begin
            next_hold = insn_valid && cbcf_running(st);
            if (cbcf_running(st)) begin
               next_ir = insn;
            end
         end
         CBCF_Q2: begin
            next_disp = dif.disp;
         end
         default: begin
            next_disp = disp;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ir   <= 16'h0000;
         hold <= 1'b0;
         disp <= '0;
      end else begin
         ir   <= next_ir;
         hold <= next_hold;
         disp <= next_disp;
      end
   end

   // process quarter: flags are read here, one quarter ahead of the pc write,
   // so the status side must hold them steady until the end of this quarter
   always_comb begin
      next_jump   = jump;
      next_target = target;
      if (q == CBCF_Q3) begin
         next_jump   = hold && dif.is_branch && dif.take;
         // pc still holds the branch word address for the whole cycle
         next_target = pc + WORD_STEP + disp;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         jump   <= 1'b0;
         target <= PC_RESET;
      end else begin
         jump   <= next_jump;
         target <= next_target;
      end
   end

   // write quarter: pc moves only here, and never in the no-op cycle
   always_comb begin
      next_pc = pc;
      if (q == CBCF_Q4 && cbcf_running(st) && hold) begin
         if (jump) begin
            next_pc = target;
         end else begin
            // step past the held word, branch or not, to the next instruction
            next_pc = pc + WORD_STEP;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc <= PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // strobes and busy level for the fetch side
   always_comb begin
      next_pc_write = 1'b0;
      next_flush    = 1'b0;
      next_busy     = busy;
      case (q)
         CBCF_Q1: begin
            if (cbcf_running(st)) begin
               next_busy = insn_valid;
            end
         end
         CBCF_Q4: begin
            if (!cbcf_running(st)) begin
               next_busy = 1'b0;
            end else if (hold) begin
               // the write strobe and the no-op marker always travel together
               next_pc_write = jump;
               next_flush    = jump;
               next_busy     = jump;
            end
         end
         default: begin
            next_busy = busy;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc_write <= 1'b0;
         flush    <= 1'b0;
         busy     <= 1'b0;
      end else begin
         pc_write <= next_pc_write;
         flush    <= next_flush;
         busy     <= next_busy;
      end
   end

endmodule : cbcf_core
`default_nettype wire

/* core/cbcf_dec_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cbcf_dec_if;
   import cbcf_pkg::*;
   logic [INSN_W-1:0] insn;
   logic [7:0]        status;
   logic              is_branch;
   logic              take;
   cbcf_pc_t          disp;
   modport dec (input insn, input status, output is_branch, output take, output disp);
   modport core (output insn, output status, input is_branch, input take, input disp);
endinterface : cbcf_dec_if
`default_nettype wire

/* core/cbcf_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module cbcf_decode (
   cbcf_dec_if.dec d
);
   import cbcf_pkg::*;
   function automatic logic [1:0] cbcf_cond(input logic [7:0] op, input logic [7:0] st);
      // {is_branch, take}
      case (op)
         OP_CARRY_CLR: cbcf_cond = {1'b1, ~st[FLAG_C]};
         OP_NEG_CLR:   cbcf_cond = {1'b1, ~st[FLAG_N]};
         OP_OVF_CLR:   cbcf_cond = {1'b1, ~st[FLAG_OV]};
         OP_NEG_SET:   cbcf_cond = {1'b1, st[FLAG_N]};
         default:      cbcf_cond = 2'b00;
      endcase
   endfunction : cbcf_cond
   logic [1:0] cond;
   always_comb begin
      cond        = cbcf_cond(d.insn[15:8], d.status);
      d.is_branch = cond[1];
      d.take      = cond[0];
      // sign-extend then double so the add wraps over the whole pc
      d.disp = {{(PC_W-9){d.insn[7]}}, d.insn[7:0], 1'b0};
   end
endmodule : cbcf_decode
`default_nettype wire

/* core/cbcf_pkg.sv */
package cbcf_pkg;
   localparam int          PC_W          = 21;
   localparam int          INSN_W        = 16;
   localparam logic [7:0]  OP_CARRY_CLR  = 8'h0_0e3;
   localparam logic [7:0]  OP_NEG_SET    = 8'h0_0e6;
   localparam logic [7:0]  OP_NEG_CLR    = 8'h0_0e7;
   localparam logic [7:0]  OP_OVF_CLR    = 8'h0_0e5;
   localparam int          FLAG_C        = 0;
   localparam int          FLAG_OV       = 3;
   localparam int          FLAG_N        = 4;
   localparam logic [PC_W-1:0] PC_RESET  = 21'h0_0000;
   localparam logic [PC_W-1:0] WORD_STEP = 21'h0_0002;
   typedef logic [PC_W-1:0] cbcf_pc_t;
   typedef enum logic [1:0] {CBCF_Q1, CBCF_Q2, CBCF_Q3, CBCF_Q4} cbcf_q_e;
   typedef enum {CBCF_RUN, CBCF_FLUSH} cbcf_st_e;
endpackage : cbcf_pkg

/* dv/cbcf_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module cbcf_asserts import cbcf_pkg::*; (
   input wire logic            sys_clk,
   input wire logic            rst,
   input wire logic            insn_valid,
   input wire logic            pc_write,
   input wire logic            flush,
   input wire logic            busy,
   input wire logic [15:0]     insn,
   input wire logic [7:0]      status_in,
   input wire logic [PC_W-1:0] pc,
   input wire logic [1:0]      q_phase
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [7:0] op, off;
   logic       go, tk;
   assign op = insn[15:8];
   assign go = q_phase == 2'h0 && !flush && insn_valid;
   assign tk = op == OP_CARRY_CLR && !status_in[FLAG_C] || op == OP_NEG_CLR && !status_in[FLAG_N]
      || op == OP_OVF_CLR && !status_in[FLAG_OV] || op == OP_NEG_SET && status_in[FLAG_N];
   always_ff @(posedge sys_clk) if (go) off <= insn[7:0];
   AST_TAKE: assert property (go && tk |-> ##4 pc_write && pc == $past(pc) + 21'h0_0002
      + {{12{off[7]}}, off, 1'h0}) else $error("bad target");
   AST_SKIP: assert property (go && !tk |-> ##4 !pc_write && pc == $past(pc) + 21'h0_0002)
      else $error("bad skip");
   AST_IDLE: assert property (q_phase == 2'h0 && !flush && !insn_valid |-> ##4 $stable(pc))
      else $error("pc moved idle");
   AST_PAIR: assert property (pc_write |-> flush && q_phase == 2'h0) else $error("bad pair");
   AST_NOP: assert property (flush |=> !pc_write [*7]) else $error("write in no-op");
   AST_FLPC: assert property (flush |-> ##4 $stable(pc)) else $error("pc moved in no-op");
   AST_QSTEP: assert property (!$past(rst) |-> q_phase == $past(q_phase) + 2'h1)
      else $error("bad quarter");
   AST_HOLD: assert property (q_phase != 2'h0 |-> $stable(pc)) else $error("pc mid-cycle");
   AST_BUSY: assert property (flush |-> busy [*4] ##1 !busy)
      else $error("busy wrong in no-op");
   AST_RUNB: assert property (go && !tk |=> busy [*3] ##1 !busy)
      else $error("busy wrong on skip");
   cover property (go && tk);
   cover property (go && !tk);
   cover property (flush ##4 go);
endmodule : cbcf_asserts
bind cbcf_core cbcf_asserts u_chk (.sys_clk, .rst, .insn_valid, .pc_write, .flush, .busy,
   .insn, .status_in, .pc, .q_phase);
`default_nettype wire

/* dv/cbcf_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cbcf_fetch_model (
   input  wire logic        sys_clk,
   input  wire logic        sel,
   input  wire logic [15:0] word,
   output logic      [15:0] insn
);
   logic [15:0] last = 16'h0000;
   // idle bus shows the inverse of the last word so a stale latch cannot pass
   assign insn = sel ? word : ~last;
   always_ff @(posedge sys_clk) if (sel) last <= word;
endmodule : cbcf_fetch_model
`default_nettype wire

/* dv/cond_branch_on_clear_flag_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cond_branch_on_clear_flag_tb;
   import cbcf_pkg::*;
   logic        sys_clk = 0, rst = 1, v = 0, e = 0, pw, fl, bz;
   logic [15:0] w = 16'h0000, insn;
   logic [7:0]  f = 8'h00, r = 8'h2f;
   logic [1:0]  q;
   cbcf_pc_t    pc, m = 21'h0;
   int          miscompares = 0, comparisons = 0, i, k;
   always #12.5 sys_clk = ~sys_clk;
   cbcf_fetch_model fm (.sys_clk, .sel(v), .word(w), .insn);
   cbcf_core dut (.sys_clk, .rst, .insn, .insn_valid(v), .status_in(f), .pc, .q_phase(q),
      .pc_write(pw), .flush(fl), .busy(bz));
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr
   task chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value %0t %h %h", $time, s, x);
      end
   endtask : chk
   task end_sim;
      $display("%0d compared, %0d wrong", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 0;
      for (k = 0; k < 300; k++) begin
         for (i = 0; i < 9 && (i == 0 || q !== 2'h0); i++) @(negedge sys_clk);
         if (q !== 2'h0) begin
            miscompares++;
            break;
         end
         chk(pc, m);
         chk(pw, e);
         chk(bz, e);
         if (k == 150) begin
            // mid-run reset; no word is offered until the first full cycle after it
            v   = 1'b0;
            rst = 1'b1;
            repeat (16) @(negedge sys_clk);
            rst = 1'b0;
            m   = 21'h0;
            e   = 1'b0;
            continue;
         end
         r = lfsr(r);
         f = lfsr(r);
         // offsets 127 and -128 go first, then opcodes e0..e7 at random
         // the second word falls in the no-op cycle, so -128 rides on the third
         w = {5'h1c, r[2:0], k < 3 ? {k[1], {7{~k[1]}}} : r};
         v = r[7] | r[6];
         e = v && !fl && (w[10:8] == 3'h3 && !f[FLAG_C] || w[10:8] == 3'h7 && !f[FLAG_N]
            || w[10:8] == 3'h5 && !f[FLAG_OV] || w[10:8] == 3'h6 && f[FLAG_N]);
         if (v && !fl) m = m + 21'h0_0002 + (e ? cbcf_pc_t'(2 * $signed(w[7:0])) : 21'h0);
         r = f;
      end
      $display("branch test done");
      end_sim;
   end
endmodule : cond_branch_on_clear_flag_tb
`default_nettype wire
